// *** hw/led_driver_diag_readout.sv ***
`timescale 1ns/100ps
module led_driver_diag_readout
  import led_diag_pkg::*;
(
  // clock and reset
  input  wire logic                    mclk_in,
  input  wire logic                    resetn_in,
  // serial pins from host or previous device
  input  wire logic                    shift_clk_in,
  input  wire logic                    serial_in_in,
  input  wire logic                    load_strobe_in,
  input  wire logic                    output_enable_n_in,
  // analog status, 1 = normal, 0 = fault
  input  wire logic                    over_temp_flag_in,
  input  wire logic [CHANNELS-1:0]     open_led_flag_in,
  input  wire logic [CHANNELS-1:0]     short_led_flag_in,
  // pins and status outputs
  output logic                         serial_out_out,
  output logic [CHANNELS-1:0]          led_sink_output_out,
  output logic                         diag_reduced_current_out,
  output logic                         shutdown_out,
  output logic                         error_mode_out
);
  import led_diag_pkg::*;

  // ----------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic [3:0] sync3_ff;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      // the enable pin idles high; resetting its stages low would fake a rise
      // after reset and capture statuses that nobody asked for
      sync1_ff <= 4'h8;
      sync2_ff <= 4'h8;
      sync3_ff <= 4'h8;
    end else begin
      sync1_ff <= {output_enable_n_in, load_strobe_in, serial_in_in, shift_clk_in};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic sin;
  logic ld_rise;
  logic ld_fall;
  logic ld_lvl;
  logic oen_lvl;
  logic oen_rise;
  logic oen_fall;

  assign sclk_rise = sync2_ff[0] & ~sync3_ff[0];
  assign sclk_fall = ~sync2_ff[0] & sync3_ff[0];
  assign sin       = sync2_ff[1];
  assign ld_lvl    = sync2_ff[2];
  assign ld_rise   = sync2_ff[2] & ~sync3_ff[2];
  assign ld_fall   = ~sync2_ff[2] & sync3_ff[2];
  assign oen_lvl   = sync2_ff[3];
  assign oen_rise  = sync2_ff[3] & ~sync3_ff[3];
  assign oen_fall  = ~sync2_ff[3] & sync3_ff[3];

  // ----------------------------------------
  // error-detection mode and pulse count
  // ----------------------------------------
  logic       err_mode_ff;
  logic [2:0] sel_ff;

  // any load fall leaves error mode, whatever count was reached
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      err_mode_ff <= 1'b0;
    end else if (ld_rise && oen_lvl) begin
      err_mode_ff <= 1'b1;
    end else if (ld_fall) begin
      err_mode_ff <= 1'b0;
    end
  end

  // the count survives load fall so the following shift cycle knows its report
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sel_ff <= SEL_TEMP;
    end else if (ld_rise && oen_lvl) begin
      sel_ff <= SEL_TEMP;
    end else if (err_mode_ff && ld_lvl && sclk_rise && sel_ff != SEL_MAX) begin
      sel_ff <= sel_ff + 3'h1;
    end
  end

  // ----------------------------------------
  // status capture on enable rise
  // ----------------------------------------
  logic                temp_cap_ff;
  logic [CHANNELS-1:0] open_cap_ff;
  logic [CHANNELS-1:0] short_cap_ff;

  // status inputs are slow analog levels, settled long before the enable rises
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      temp_cap_ff  <= 1'b1;
      open_cap_ff  <= STATUS_OK;
      short_cap_ff <= STATUS_OK;
    end else if (oen_rise) begin
      temp_cap_ff  <= over_temp_flag_in;
      open_cap_ff  <= open_led_flag_in;
      short_cap_ff <= short_led_flag_in;
    end
  end

  // ----------------------------------------
  // shift register and data register
  // ----------------------------------------
  logic [CHANNELS-1:0] sr_ff;
  logic [CHANNELS-1:0] data_ff;
  logic [CHANNELS-1:0] nxt_report;

  // the seven spare bits of the temperature word read as zero
  always_comb begin
    case (sel_ff)
      SEL_OPEN:   nxt_report = open_cap_ff;
      SEL_SHORT:  nxt_report = short_cap_ff;
      SEL_LOWCUR: nxt_report = ALL_ONES;
      default:    nxt_report = {TEMP_PAD, temp_cap_ff};
    endcase
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sr_ff <= SR_RST;
    end else if (ld_fall && err_mode_ff) begin
      sr_ff <= nxt_report;
    end else if (sclk_rise && !err_mode_ff) begin
      // selection pulses in error mode must not disturb the loaded report
      // new bit enters at the top, LSB leaves toward the next device
      sr_ff <= {sin, sr_ff[CHANNELS-1:1]};
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      data_ff <= DATA_RST;
    end else if (ld_rise) begin
      // taken on every load rise, error-mode entry included
      data_ff <= sr_ff;
    end
  end

  // ----------------------------------------
  // serial output: LSB stage on rise, pin on fall outside error mode, gated input in error mode
  // ----------------------------------------
  logic lsb_stage_ff;
  logic gate_flag;

  // the pin follows the shift clock pin by three mclk cycles, so the host
  // must keep shift clock phases well above that
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lsb_stage_ff <= 1'b0;
    end else if (sclk_rise) begin
      lsb_stage_ff <= sr_ff[0];
    end
  end

  // global flag ANDed into the chain; pass-through for mode 3 and 4 selection
  always_comb begin
    case (sel_ff)
      SEL_TEMP:  gate_flag = temp_cap_ff;
      SEL_OPEN:  gate_flag = &(open_cap_ff | ~data_ff);
      SEL_SHORT: gate_flag = &(short_cap_ff | ~data_ff);
      default:   gate_flag = 1'b1;
    endcase
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      serial_out_out <= 1'b1;
    end else if (err_mode_ff) begin
      serial_out_out <= sin & gate_flag;
    end else if (sclk_fall) begin
      serial_out_out <= lsb_stage_ff;
    end
  end

  // ----------------------------------------
  // low-current diagnostic mode
  // ----------------------------------------
  logic lc_armed_ff;

  // the arm survives until the reduced-current window closes on enable rise
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lc_armed_ff <= 1'b0;
    end else if (ld_fall && err_mode_ff && sel_ff == SEL_LOWCUR) begin
      lc_armed_ff <= 1'b1;
    end else if (oen_rise && diag_reduced_current_out) begin
      lc_armed_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      diag_reduced_current_out <= 1'b0;
    end else if (oen_fall && lc_armed_ff) begin
      diag_reduced_current_out <= 1'b1;
    end else if (oen_rise) begin
      diag_reduced_current_out <= 1'b0;
    end
  end

  // ----------------------------------------
  // shutdown / wakeup
  // ----------------------------------------
  // shutdown only darkens the channels; the serial chain keeps working
  // a count of three at a rise marks that rise as the fourth pulse
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      shutdown_out <= 1'b0;
    end else if (err_mode_ff && ld_lvl && sclk_rise && sel_ff == SEL_LOWCUR) begin
      // this rise is the fourth pulse
      shutdown_out <= ~sin;
    end
  end

  // registered copy for the pin, one cycle behind the internal flag
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      error_mode_out <= 1'b0;
    end else begin
      error_mode_out <= err_mode_ff;
    end
  end

  // ----------------------------------------
  // staggered output turn-on
  // ----------------------------------------
  // each channel times its own turn-on, so a data load or a wakeup while the
  // enable is low is staggered as well, not only the enable fall
  // STG_W bounds the longest delay; it must hold the last channel's count
  genvar k;
  generate
    for (k = 0; k < CHANNELS; k++) begin : g_ch
      localparam logic [STG_W-1:0] DLY = STG_W'(k * STAGGER_CYC);
      logic             want;
      logic [STG_W-1:0] wait_cnt_ff;

      assign want = data_ff[k] & ~oen_lvl & ~shutdown_out;

      always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          wait_cnt_ff <= '0;
        end else if (!want) begin
          wait_cnt_ff <= '0;
        end else if (wait_cnt_ff != DLY) begin
          wait_cnt_ff <= wait_cnt_ff + STG_W'(1);
        end
      end

      always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          led_sink_output_out[k] <= 1'b0;
        end else begin
          led_sink_output_out[k] <= want & (wait_cnt_ff == DLY);
        end
      end
    end
  endgenerate

endmodule

// *** hw/led_diag_pkg.sv ***
package led_diag_pkg;

  // ----------------------------------------
  // geometry
  // ----------------------------------------
  localparam int          CHANNELS   = 8;
  localparam int          TEMP_BIT   = 0;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          STAGGER_NS    = 20;
  localparam int          STAGGER_CYC   = (STAGGER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          STG_W         = 8;
  localparam logic [7:0]  STG_MAX       = 8'hFF;

  // ----------------------------------------
  // error-mode selection by shift-clock pulse count
  // ----------------------------------------
  localparam logic [2:0]  SEL_TEMP     = 3'h0;
  localparam logic [2:0]  SEL_OPEN     = 3'h1;
  localparam logic [2:0]  SEL_SHORT    = 3'h2;
  localparam logic [2:0]  SEL_LOWCUR   = 3'h3;
  localparam logic [2:0]  SEL_SHUTDOWN = 3'h4;
  localparam logic [2:0]  SEL_MAX      = 3'h7;

  // ----------------------------------------
  // reset values and patterns
  // ----------------------------------------
  localparam logic [7:0]  SR_RST       = 8'h00;
  localparam logic [7:0]  DATA_RST     = 8'h00;
  localparam logic [7:0]  ALL_ONES     = 8'hFF;
  localparam logic [6:0]  TEMP_PAD     = 7'h00;
  localparam logic [7:0]  STATUS_OK    = 8'hFF;

endpackage

// *** testbench/led_diag_sva.sv ***
`timescale 1ns/100ps
module led_diag_sva
  import led_diag_pkg::*;
(
  // clock and reset
  input wire logic                mclk_in,
  input wire logic                resetn_in,
  // watched pins
  input wire logic                load_strobe_in,
  input wire logic                output_enable_n_in,
  input wire logic [CHANNELS-1:0] led_sink_output_out,
  input wire logic                diag_reduced_current_out,
  input wire logic                shutdown_out,
  input wire logic                error_mode_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!resetn_in);

  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence s_err_entry;
    $rose(load_strobe_in) && output_enable_n_in;
  endsequence
  sequence s_enable_release;
    $rose(output_enable_n_in);
  endsequence

  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_err_entry: assert property (s_err_entry |-> ##[2:6] error_mode_out)
    else $error("error mode not entered after load rise");
  a_err_cause: assert property ($rose(error_mode_out) |-> load_strobe_in && output_enable_n_in)
    else $error("error mode entered without load high and enable off");
  a_diag_restore: assert property (s_enable_release |-> ##[1:6] !diag_reduced_current_out)
    else $error("reduced current kept after enable release");
  a_diag_cause: assert property ($rose(diag_reduced_current_out) |-> !output_enable_n_in)
    else $error("reduced current raised while enable off");
  a_dark_disabled: assert property (output_enable_n_in [*8] |-> led_sink_output_out == 8'h00)
    else $error("channels on while enable off");
  a_dark_shutdown: assert property (shutdown_out [*8] |-> led_sink_output_out == 8'h00)
    else $error("channels on in shutdown");
  a_sd_in_err: assert property ($changed(shutdown_out) |-> error_mode_out)
    else $error("shutdown changed outside error mode");
  // slack of two cycles against the 14-cycle spread of channel seven
  a_stagger_span: assert property ($rose(led_sink_output_out[7]) && led_sink_output_out[0]
    |-> $past(led_sink_output_out[0], 12))
    else $error("channel seven not delayed behind channel zero");
endmodule

bind led_driver_diag_readout led_diag_sva u_sva (
  .mclk_in(mclk_in), .resetn_in(resetn_in), .load_strobe_in(load_strobe_in),
  .output_enable_n_in(output_enable_n_in), .led_sink_output_out(led_sink_output_out),
  .diag_reduced_current_out(diag_reduced_current_out), .shutdown_out(shutdown_out),
  .error_mode_out(error_mode_out)
);

// *** testbench/led_host_model.sv ***
`timescale 1ns/100ps
module led_host_model (
  input  wire logic mclk_in,
  output logic      shift_clk_out,
  output logic      serial_data_out,
  output logic      load_strobe_out,
  output logic      output_enable_n_out
);
  // ----------------------------------------
  // pin idle levels
  // ----------------------------------------
  initial begin
    shift_clk_out = 1'b0;
    serial_data_out = 1'b1;
    load_strobe_out = 1'b0;
    output_enable_n_out = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge mclk_in);
  endtask

  // pin edges stay 4+ cycles apart since the device oversamples its pins
  task automatic clk_bit(input logic d);
    @(posedge mclk_in) serial_data_out <= d;
    hold(4);
    shift_clk_out <= 1'b1;
    hold(4);
    shift_clk_out <= 1'b0;
    hold(6);
  endtask

  task automatic set_load(input logic v);
    @(posedge mclk_in) load_strobe_out <= v;
    hold(6);
  endtask

  task automatic set_oen(input logic v);
    @(posedge mclk_in) output_enable_n_out <= v;
    hold(6);
  endtask
endmodule

// *** testbench/led_driver_diag_readout_test.sv ***
`timescale 1ns/100ps
module led_driver_diag_readout_test;
  import led_diag_pkg::*;
  logic       mclk_in = 1'b0;
  logic       resetn_in;
  logic       sclk, serial_in, ld, oen_n, serial_out, diag, sd, em;
  logic       temp_ok;
  logic [7:0] open_ok;
  logic [7:0] short_ok;
  logic [7:0] leds, got;
  int         bad_count = 0;
  int         n_checks = 0;
  int         cycles = 0;

  initial begin
    forever #5 mclk_in = ~mclk_in;
  end

  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      close_out();
    end
  end

  led_host_model u_host (.mclk_in(mclk_in), .shift_clk_out(sclk), .serial_data_out(serial_in),
    .load_strobe_out(ld), .output_enable_n_out(oen_n));

  led_driver_diag_readout u_dut (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .shift_clk_in(sclk), .serial_in_in(serial_in), .load_strobe_in(ld),
    .output_enable_n_in(oen_n), .over_temp_flag_in(temp_ok), .open_led_flag_in(open_ok),
    .short_led_flag_in(short_ok), .serial_out_out(serial_out), .led_sink_output_out(leds),
    .diag_reduced_current_out(diag), .shutdown_out(sd), .error_mode_out(em));

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // one device word, LSB first on both pins
  task automatic shift8(input logic [7:0] din, output logic [7:0] dout);
    for (int i = 0; i < 8; i++) begin
      u_host.clk_bit(din[i]);
      dout[i] = serial_out;
    end
  endtask

  task automatic readout(input int sel, output logic [7:0] dout);
    repeat (sel) u_host.clk_bit(1'b1);
    u_host.set_load(1'b0);
    // zeros in, so a later internal all-ones load cannot come from the shift path
    shift8(8'h00, dout);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    resetn_in <= 1'b0;
    temp_ok   <= 1'b1;
    open_ok   <= 8'hFF;
    short_ok  <= 8'hFF;
    repeat (16) @(posedge mclk_in);
    resetn_in <= 1'b1;
    u_host.hold(4);
    chk({serial_out, diag, sd, em, 4'h0}, 8'h80);
    chk(leds, 8'h00);
    $display("reset test done");
    shift8(8'h5A, got);
    shift8(8'h3C, got);
    chk(got, 8'h5A);
    u_host.set_oen(1'b0);
    u_host.set_load(1'b1);
    u_host.set_load(1'b0);
    u_host.hold(30);
    chk(leds, 8'h3C);
    $display("stream test done");
    for (int t = 0; t < 2; t++) begin
      @(posedge mclk_in) temp_ok <= t[0];
      u_host.set_oen(1'b0);
      u_host.set_oen(1'b1);
      u_host.set_load(1'b1);
      chk({7'h00, em}, 8'h01);
      readout(0, got);
      chk({7'h00, got[0]}, {7'h00, t[0]});
    end
    $display("temperature test done");
    // the second pair of passes inverts the fault patterns, so every status bit
    // is seen both ways
    for (int p = 0; p < 4; p++) begin
      @(posedge mclk_in) open_ok <= (p < 2) ? 8'hE7 : 8'h18;
      short_ok <= (p < 2) ? 8'h9F : 8'h60;
      u_host.set_load(1'b1);
      repeat (3) u_host.clk_bit(1'b1);
      u_host.set_load(1'b0);
      u_host.set_load(1'b1);
      u_host.set_oen(1'b0);
      u_host.hold(100);
      chk({7'h00, diag}, 8'h01);
      chk(leds, 8'hFF);
      u_host.hold(94);
      u_host.set_oen(1'b1);
      chk({7'h00, diag}, 8'h00);
      readout(1 + p % 2, got);
      chk(got, (p % 2 == 0) ? open_ok : short_ok);
    end
    shift8(8'hFF, got);
    chk(got, 8'h00);
    $display("low current test done");
    for (int w = 0; w < 2; w++) begin
      u_host.set_load(1'b1);
      repeat (3) u_host.clk_bit(1'b1);
      u_host.clk_bit(w[0]);
      chk({7'h00, sd}, {7'h00, ~w[0]});
      u_host.set_load(1'b0);
      u_host.set_oen(1'b0);
      u_host.hold(30);
      chk(leds, (w == 0) ? 8'h00 : {TEMP_PAD, 1'b1});
      u_host.set_oen(1'b1);
    end
    $display("shutdown test done");
    close_out();
  end
endmodule
